// file: common/iesb_defs.svh
// Offsets, reset values, vector base and unused source number for the enable/status banks
// Notes on behaviour
// - Low bank enable register, 16 bits read/write, resets to all ones.
// - Low bank enable bit n gates source n; one enables, zero blocks.
// - Low bank enable bit 0 has no effect on any request.
// - Low bank status register, 16 bits read-only, shows active sources 1 to 15.
// - Status shows raw requests regardless of enable bits.
// - Low bank status bits 15 down to 1 follow sources 15 down to 1.
// - Low bank status bit 0 always returns a fixed value.
// - Mid bank enable register gates sources 16 to 31, resets to all ones.
// - Mid bank status register, read-only, shows active sources 16 to 31.
// - Only active and enabled requests reach the encoder; highest wins, source 0 is 10h.
`ifndef IESB_DEFS_SVH
`define IESB_DEFS_SVH
`define IESB_OFS_EN_LOW 12'h000
`define IESB_OFS_ACT_LOW 12'h004
`define IESB_OFS_EN_MID 12'h008
`define IESB_OFS_ACT_MID 12'h00c
`define IESB_OFS_EVT_STAT 12'h010
`define IESB_OFS_EVT_MASK 12'h014
`define IESB_OFS_VECTOR 12'h018
`define IESB_EN_RESET 16'hffff
`define IESB_VEC_BASE 8'h10
`define IESB_UNUSED_SRC 0
`endif

// file: common/iesb_pkg.sv
// Types shared by the enable/status bank modules
`default_nettype none
package iesb_pkg;
   typedef logic [15:0] iesb_half_t;
   typedef logic [31:0] iesb_word_t;
   typedef enum logic [1:0] {IESB_IDLE, IESB_SETUP, IESB_ACCESS} iesb_phase_e;
endpackage : iesb_pkg
`default_nettype wire

// file: common/iesb_vec_if.sv
// Enabled-pending vector passed from the banks to the encoder
`default_nettype none
interface iesb_vec_if;
   logic [31:0] pend;
   logic [7:0] vector;
   logic any;
   modport banks (output pend, input vector, input any);
   modport enc (input pend, output vector, output any);
endinterface : iesb_vec_if
`default_nettype wire

// file: rtl/iesb_banks.sv
// Enable and status banks for sources 1 to 31 with APB access and event interrupt
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none
`include "iesb_defs.svh"
module iesb_banks #(
   parameter int unsigned ADDR_W = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request lines, source 0 unused
   input wire logic [31:0] irq_req,
   // Enabled-pending vector to the encoder
   output logic [31:0] irq_pend,
   output logic [7:0] irq_vector,
   output logic irq_any,
   // Interrupt out
   output logic irq_out
);
   iesb_vec_if vec ();

   iesb_encoder u_enc (
      .pclk(pclk),
      .presetn(presetn),
      .vec(vec)
   );

   iesb_pkg::iesb_half_t en_low_q;
   iesb_pkg::iesb_half_t en_mid_q;
   logic [1:0] evt_stat_q;
   logic [1:0] evt_mask_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic any_prev_q;

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      return a == ADDR_W'(ofs);
   endfunction : addr_is

   wire logic acc_w = psel & penable;
   wire logic wr_w = acc_w & pwrite;
   wire logic rd_w = acc_w & ~pwrite;
   wire logic sel_en_low = addr_is(paddr, `IESB_OFS_EN_LOW);
   wire logic sel_act_low = addr_is(paddr, `IESB_OFS_ACT_LOW);
   wire logic sel_en_mid = addr_is(paddr, `IESB_OFS_EN_MID);
   wire logic sel_act_mid = addr_is(paddr, `IESB_OFS_ACT_MID);
   wire logic sel_stat = addr_is(paddr, `IESB_OFS_EVT_STAT);
   wire logic sel_mask = addr_is(paddr, `IESB_OFS_EVT_MASK);
   wire logic sel_vec = addr_is(paddr, `IESB_OFS_VECTOR);
   wire logic mapped_w = sel_en_low | sel_act_low | sel_en_mid | sel_act_mid |
      sel_stat | sel_mask | sel_vec;

   // Raw status, bit 0 forced low since that source is not wired
   wire iesb_pkg::iesb_half_t act_low_w = {irq_req[15:1], 1'b0};
   wire iesb_pkg::iesb_half_t act_mid_w = irq_req[31:16];
   // Enable bit 0 of the low bank is masked off here
   wire iesb_pkg::iesb_half_t gate_low_w = {en_low_q[15:1], 1'b0};
   wire logic [31:0] pend_w = {act_mid_w & en_mid_q, act_low_w & gate_low_w};

   assign vec.pend = pend_w;

   // Events: pending set goes from empty to non-empty, or all pending requests vanish
   wire logic [1:0] evt_w = {any_prev_q & ~vec.any, ~any_prev_q & vec.any};
   wire logic [1:0] clr_w = (wr_w & sel_stat) ? pwdata[1:0] : 2'b00;

   logic [31:0] rd_mux_w;
   always_comb begin
      rd_mux_w = 32'h0000_0000;
      if (sel_en_low) begin
         rd_mux_w = {16'h0000, en_low_q};
      end else if (sel_act_low) begin
         rd_mux_w = {16'h0000, act_low_w};
      end else if (sel_en_mid) begin
         rd_mux_w = {16'h0000, en_mid_q};
      end else if (sel_act_mid) begin
         rd_mux_w = {16'h0000, act_mid_w};
      end else if (sel_stat) begin
         rd_mux_w = {30'h0, evt_stat_q};
      end else if (sel_mask) begin
         rd_mux_w = {30'h0, evt_mask_q};
      end else if (sel_vec) begin
         rd_mux_w = {24'h0, vec.vector};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_low_q <= `IESB_EN_RESET;
         en_mid_q <= `IESB_EN_RESET;
      end else if (wr_w & sel_en_low) begin
         en_low_q <= pwdata[15:0];
      end else if (wr_w & sel_en_mid) begin
         en_mid_q <= pwdata[15:0];
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_stat_q <= 2'b00;
         evt_mask_q <= 2'b00;
         any_prev_q <= 1'b0;
      end else begin
         evt_stat_q <= (evt_stat_q & ~clr_w) | evt_w;
         any_prev_q <= vec.any;
         if (wr_w & sel_mask) begin
            evt_mask_q <= pwdata[1:0];
         end
      end
   end

   // Read data registered at the edge that ends the setup phase; zero-wait answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (psel & ~penable) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_mux_w;
         pslverr_q <= ~mapped_w;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = acc_w & pslverr_q;
   assign irq_pend = pend_w;
   assign irq_vector = vec.vector;
   assign irq_any = vec.any;
   assign irq_out = |(evt_stat_q & evt_mask_q);

   a_en_reset_ones: assert property (@(posedge pclk)
      $rose(presetn) |-> en_low_q == 16'hffff && en_mid_q == 16'hffff)
      else $error("enable banks not all ones after reset");
   a_en_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_w && sel_en_low) |=> en_low_q == $past(pwdata[15:0]))
      else $error("low enable write lost");
   a_bit0_no_effect: assert property (@(posedge pclk) disable iff (!presetn)
      irq_pend[0] == 1'b0) else $error("source 0 reached encoder");
   a_status_raw: assert property (@(posedge pclk) disable iff (!presetn)
      act_low_w[15:1] == irq_req[15:1]) else $error("low status not raw");
   a_status_bit0: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && sel_act_low) |=> prdata[0] == 1'b0)
      else $error("status bit 0 not zero");
   a_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_w && (sel_act_low || sel_act_mid)) |=> $stable(en_low_q) && $stable(en_mid_q))
      else $error("status write changed state");
   a_pend_gated: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_req[20] && !en_mid_q[4]) |-> !irq_pend[20] && (irq_req[20] == act_mid_w[4]))
      else $error("disabled source forwarded or hidden");
   a_mid_status: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && sel_act_mid) |=> prdata[15:0] == $past(irq_req[31:16]))
      else $error("mid status read wrong");
   a_pend_and: assert property (@(posedge pclk) disable iff (!presetn)
      irq_pend[31:16] == (irq_req[31:16] & en_mid_q)) else $error("mid pend wrong");
   a_vec_base: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_pend == 32'h0000_0000) |=> irq_vector == 8'h10) else $error("idle vector wrong");

   // Setup cycle to an address outside the map
   sequence s_unmapped_setup;
      psel && !penable && !mapped_w;
   endsequence : s_unmapped_setup
   // Pending set goes from empty to non-empty
   sequence s_pend_rise;
      !irq_any ##1 irq_any;
   endsequence : s_pend_rise

   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      s_unmapped_setup ##1 acc_w |-> pslverr) else $error("unmapped access not flagged");
   a_evt_rise_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_pend_rise |=> evt_stat_q[0]) else $error("pending rise event lost");
endmodule : iesb_banks
`default_nettype wire

// file: rtl/iesb_encoder.sv
// Fixed-priority encoder over the enabled-pending vector
`default_nettype none
`include "iesb_defs.svh"
module iesb_encoder (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pending vector in, vector out
   iesb_vec_if.enc vec
);
   function automatic logic [4:0] top_index(input logic [31:0] p);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (p[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction : top_index

   wire logic [4:0] top_w = top_index(vec.pend);
   logic [7:0] vector_q;
   logic any_q;

   // Registered so a read sees a settled value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_q <= `IESB_VEC_BASE;
         any_q <= 1'b0;
      end else begin
         vector_q <= `IESB_VEC_BASE + {3'h0, top_w};
         any_q <= |vec.pend;
      end
   end
   assign vec.vector = vector_q;
   assign vec.any = any_q;

   a_vector_top: assert property (@(posedge pclk) disable iff (!presetn)
      (vec.pend[31] |=> vec.vector == 8'h2f)) else $error("vector not top source");
endmodule : iesb_encoder
`default_nettype wire

// file: tb/iesb_src_model.sv
// Model of the peripheral request sources
`default_nettype none
module iesb_src_model (
   // Clock
   input wire logic pclk,
   // Pattern asked for by the bench
   input wire logic [31:0] want,
   // Level request lines
   output logic [31:0] irq_req
);
   initial irq_req = 32'h0;
   // Registered, so lines move just after an edge as a peripheral would
   always @(posedge pclk) irq_req <= want;
endmodule : iesb_src_model
`default_nettype wire

// file: tb/irq_enable_status_banks_tb_top.sv
// Self-checking bench for the enable and status banks
`default_nettype none
module irq_enable_status_banks_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, prdy, perr, er, irq_any, irq_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, irq_req, irq_pend, want, rd;
   logic [7:0] irq_vector;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   iesb_banks dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(prdy),
      .pslverr(perr), .irq_req(irq_req), .irq_pend(irq_pend), .irq_vector(irq_vector),
      .irq_any(irq_any), .irq_out(irq_out));
   iesb_src_model src_m (.pclk(pclk), .want(want), .irq_req(irq_req));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Ceiling well above the roughly 460 cycles the tests need
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Waits for pready rather than assuming zero wait states
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (prdy !== 1'b1);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Looks on the falling edge so flags launched by the last rising edge have settled
   task automatic src(input logic [31:0] v);
      @(posedge pclk);
      want <= v;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask : src
   task automatic t_reset;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000ffff);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000ffff);
      $display("test reset done");
   endtask : t_reset
   task automatic t_status;
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      src(32'ha5a5c3c3);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000c3c2);
      apb(1'b1, 12'h004, 32'hffff);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000c3c2);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0000a5a5);
      chk(irq_pend, 32'h0);
      apb(1'b1, 12'h000, 32'hffff);
      apb(1'b1, 12'h008, 32'hffff);
      src(32'h1);
      chk(irq_pend, 32'h0);
      chk({24'h0, irq_vector}, 32'h10);
      chk({31'h0, irq_any}, 32'h0);
      $display("test status done");
   endtask : t_status
   task automatic t_walk;
      logic [31:0] b;
      logic [11:0] a;
      for (int n = 1; n < 32; n++) begin
         b = 32'h1 << n;
         a = (n < 16) ? 12'h000 : 12'h008;
         src(b);
         chk(irq_pend, b);
         chk({24'h0, irq_vector}, 32'(n) + 32'h10);
         chk({31'h0, irq_any}, 32'h1);
         apb(1'b1, a, 32'hffff & ~(32'h1 << (n % 16)));
         @(posedge pclk);
         chk(irq_pend, 32'h0);
         apb(1'b1, a, 32'hffff);
      end
      $display("test walk done");
   endtask : t_walk
   task automatic t_event;
      src(32'h0);
      apb(1'b1, 12'h014, 32'h1);
      apb(1'b1, 12'h010, 32'h3);
      @(posedge pclk);
      chk({31'h0, irq_out}, 32'h0);
      src(32'h80);
      chk({31'h0, irq_out}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, 12'h014, 32'h0);
      @(posedge pclk);
      chk({31'h0, irq_out}, 32'h0);
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, 32'h17);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test event done");
   endtask : t_event
   // Second reset in mid-run must bring the enables back to all ones
   task automatic t_rst_mid;
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h014, 32'h2);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000ffff);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000ffff);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0);
      $display("test mid-run reset done");
   endtask : t_rst_mid
   task automatic stop_test;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      want = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_status();
      t_walk();
      t_event();
      t_rst_mid();
      stop_test();
   end
endmodule : irq_enable_status_banks_tb_top
`default_nettype wire
